// ### rtl/standby_watchdog_pkg.sv
// Constants and carrier types for the standby and watchdog control block
// How it works
// - Two crystal-rate clock enables are made, one for timers and interrupts and one for the rest of the core.
// - In halt the core clock enable is held off while the oscillator and timer clock keep running.
// - An enabled interrupt ends halt and the program resumes after the halt instruction.
// - In stop the oscillator is turned off so both internal clocks stop.
// - Stop is left only by a reset or by a high level on the wake pin.
// - Leaving stop by either way starts fetching at address 000C.
// - After any reset execution starts at address 000C.
// - The watchdog is always enabled in run mode and resets the device when not refreshed there within 12 ms.
// - The watchdog count is cleared at power-on and by each refresh instruction.
// - The halt-mode watchdog enable instruction keeps the watchdog counting during halt.
// - With halt counting enabled, a reset follows if halt is not left nor the watchdog refreshed within 12 ms.
// - The refresh instruction updates the zero, sign and overflow flags.
// - The watchdog does not count in stop and cannot reset the device there.
// - Global reset is asserted while the supply-drop detector reports low supply.
package standby_watchdog_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_PS    = 8000;
  localparam longint      WDOG_TIMEOUT_NS  = 12000000;   // 12 ms
  localparam int          WDOG_CYCLES      = int'((WDOG_TIMEOUT_NS * 1000) / CLK_PERIOD_PS);
  localparam int          OSC_START_CYCLES = 16;         // Oscillator settle after wake
  localparam int          RST_STRETCH      = 5;          // Minimum internal reset width

  // ----------------------------------------------------------------
  // Addresses and opcodes
  // ----------------------------------------------------------------
  localparam logic [15:0] START_ADDR       = 16'h000C;
  localparam logic [7:0]  OP_NOP           = 8'hFF;
  localparam logic [7:0]  OP_STOP          = 8'h6F;
  localparam logic [7:0]  OP_HALT          = 8'h7F;
  localparam logic [7:0]  OP_WDOG_HALT     = 8'h4F;
  localparam logic [7:0]  OP_WDOG_REFRESH  = 8'h5F;      // Refresh opcode

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP = 2'b11,
    ST_WAKE = 2'b10
  } mode_t;

  // Instruction strobe from the core decoder
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } instr_t;

  // Flag update for zero, sign, overflow
  typedef struct packed {
    logic upd;
    logic z;
    logic s;
    logic v;
  } flags_t;

endpackage

// ### rtl/watchdog_counter.sv
// Watchdog counter with clear, run gate and timeout pulse
`timescale 1ns/1ps
module watchdog_counter #(
  parameter int LIMIT = 1500000
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_clear,
  input  wire logic i_run,
  output logic      o_timeout
);

  localparam int W = $clog2(LIMIT + 1);

  initial begin
    if (LIMIT < 2) begin
      $error("watchdog LIMIT too small");
    end
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         to;
  } wd_state_t;

  wd_state_t s_q;
  wd_state_t s_d;

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  // Clear wins over counting; hold while not running
  always_comb begin
    s_d    = s_q;
    s_d.to = 1'b0;
    if (i_clear) begin
      s_d.cnt = '0;
    end else if (i_run) begin
      if (s_q.cnt == W'(LIMIT - 1)) begin
        s_d.cnt = '0;
        s_d.to  = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_timeout = s_q.to;

endmodule

// ### rtl/standby_watchdog_control.sv
// Standby mode, watchdog and reset sequencing for the core
`timescale 1ns/1ps
module standby_watchdog_control #(
  parameter int WDOG_LIMIT = standby_watchdog_pkg::WDOG_CYCLES,
  parameter int OSC_START  = standby_watchdog_pkg::OSC_START_CYCLES
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_resetn,
  input  wire logic                         i_supply_drop_reset,
  input  wire logic                         i_wake_input_pin,
  input  wire standby_watchdog_pkg::instr_t i_instr,
  input  wire logic                         i_irq_pending,
  output logic                              o_core_clk_en,
  output logic                              o_timer_interrupt_clock_en,
  output logic                              o_osc_enable,
  output logic                              o_core_reset_n,
  output logic                              o_load_pc,
  output logic [15:0]                       o_pc_value,
  output standby_watchdog_pkg::flags_t      o_flags,
  output standby_watchdog_pkg::mode_t       o_mode,
  output logic                              o_watchdog_reset
);

  localparam int OW = $clog2(OSC_START + 1);
  localparam int RW = $clog2(standby_watchdog_pkg::RST_STRETCH + 1);

  initial begin
    if (OSC_START < 1) begin
      $error("OSC_START must be at least 1");
    end
  end

  // ----------------------------------------------------------------
  // Reset synchroniser, shared by pin and supply drop
  // ----------------------------------------------------------------
  logic       pin_rst_n;
  logic [1:0] rsync_q;
  logic       wd_timeout;

  // Reset pin and supply-drop both assert the async reset
  assign pin_rst_n = i_resetn & ~i_supply_drop_reset;

  always_ff @(posedge i_clk or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end

  logic rst_n;
  assign rst_n = rsync_q[1];

  // ----------------------------------------------------------------
  // Wake pin: asynchronous latch while the clock is stopped
  // ----------------------------------------------------------------
  logic wake_seen_q;
  logic stop_active;
  logic [1:0] wsync_q;

  // Level on the pin sets the latch without a clock
  always_ff @(posedge i_clk or posedge i_wake_input_pin) begin
    if (i_wake_input_pin) begin
      wake_seen_q <= 1'b1;
    end else if (!stop_active) begin
      wake_seen_q <= 1'b0;
    end
  end

  // Two flops before use
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wsync_q <= 2'b00;
    end else begin
      wsync_q <= {wsync_q[0], wake_seen_q};
    end
  end

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  typedef struct packed {
    standby_watchdog_pkg::mode_t  mode;
    logic                         wd_halt_en;
    logic [OW-1:0]                osc_cnt;
    logic [RW-1:0]                rst_cnt;
    logic                         load_pc;
    standby_watchdog_pkg::flags_t flags;
    logic                         wd_rst;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;

  logic refresh;
  logic wd_run;

  assign refresh = i_instr.valid && i_instr.opcode == standby_watchdog_pkg::OP_WDOG_REFRESH;
  assign stop_active = (s_q.mode == standby_watchdog_pkg::ST_STOP);

  // Runs in run mode, in halt only once enabled, never in stop
  assign wd_run = (s_q.mode == standby_watchdog_pkg::ST_RUN) ||
                  (s_q.mode == standby_watchdog_pkg::ST_HALT && s_q.wd_halt_en);

  watchdog_counter #(
    .LIMIT (WDOG_LIMIT)
  ) u_wdog (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_clear   (refresh),
    .i_run     (wd_run),
    .o_timeout (wd_timeout)
  );

  // Next-state logic
  always_comb begin
    s_d         = s_q;
    s_d.load_pc = 1'b0;
    s_d.flags   = '0;
    if (s_q.rst_cnt != '0) begin
      s_d.rst_cnt = s_q.rst_cnt - RW'(1);
    end else begin
      s_d.wd_rst = 1'b0;
    end
    // Watchdog timeout restarts the core through its own reset stretch, not the global reset
    if (wd_timeout) begin
      s_d.wd_rst     = 1'b1;
      s_d.rst_cnt    = RW'(standby_watchdog_pkg::RST_STRETCH);
      s_d.mode       = standby_watchdog_pkg::ST_RUN;
      s_d.wd_halt_en = 1'b0;
      s_d.load_pc    = 1'b1;
    end else begin
      // Refresh sets zero, clears sign and overflow
      if (refresh) begin
        s_d.flags = '{upd: 1'b1, z: 1'b1, s: 1'b0, v: 1'b0};
      end
      unique case (s_q.mode)
        standby_watchdog_pkg::ST_RUN: begin
          if (i_instr.valid && i_instr.opcode == standby_watchdog_pkg::OP_WDOG_HALT) begin
            s_d.wd_halt_en = 1'b1;
          end
          if (i_instr.valid && i_instr.opcode == standby_watchdog_pkg::OP_HALT) begin
            s_d.mode = standby_watchdog_pkg::ST_HALT;
          end else if (i_instr.valid && i_instr.opcode == standby_watchdog_pkg::OP_STOP) begin
            s_d.mode = standby_watchdog_pkg::ST_STOP;
          end
        end
        standby_watchdog_pkg::ST_HALT: begin
          // Core resumes where it left; interrupt service follows
          if (i_irq_pending) begin
            s_d.mode = standby_watchdog_pkg::ST_RUN;
          end
        end
        standby_watchdog_pkg::ST_STOP: begin
          if (wsync_q[1]) begin
            s_d.mode    = standby_watchdog_pkg::ST_WAKE;
            s_d.osc_cnt = OW'(OSC_START);
          end
        end
        standby_watchdog_pkg::ST_WAKE: begin
          if (s_q.osc_cnt == OW'(1)) begin
            s_d.mode    = standby_watchdog_pkg::ST_RUN;
            s_d.load_pc = 1'b1;
          end else begin
            s_d.osc_cnt = s_q.osc_cnt - OW'(1);
          end
        end
      endcase
    end
  end

  // State register; load start address after reset release
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.load_pc <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_core_clk_en              = rst_n && s_q.mode == standby_watchdog_pkg::ST_RUN;
  assign o_timer_interrupt_clock_en = rst_n && (s_q.mode == standby_watchdog_pkg::ST_RUN ||
                                       s_q.mode == standby_watchdog_pkg::ST_HALT);
  assign o_osc_enable               = !stop_active;
  assign o_core_reset_n             = rst_n && !s_q.wd_rst;
  assign o_load_pc                  = s_q.load_pc;
  assign o_pc_value                 = standby_watchdog_pkg::START_ADDR;
  assign o_flags                    = s_q.flags;
  assign o_mode                     = s_q.mode;
  assign o_watchdog_reset           = s_q.wd_rst;

endmodule

// ### testbench/standby_watchdog_control_asserts.sv
// Checker for standby modes, wake, watchdog and reset of the control block
`timescale 1ns/1ps
module standby_watchdog_control_asserts #(
  parameter int WDOG_LIMIT = 100,
  parameter int OSC_START  = 2
) (
  input wire logic                         i_clk,
  input wire logic                         i_resetn,
  input wire logic                         i_supply_drop_reset,
  input wire logic                         i_wake_input_pin,
  input wire standby_watchdog_pkg::instr_t i_instr,
  input wire logic                         i_irq_pending,
  input wire logic                         o_core_clk_en,
  input wire logic                         o_timer_interrupt_clock_en,
  input wire logic                         o_osc_enable,
  input wire logic                         o_core_reset_n,
  input wire logic                         o_load_pc,
  input wire logic [15:0]                  o_pc_value,
  input wire standby_watchdog_pkg::flags_t o_flags,
  input wire standby_watchdog_pkg::mode_t  o_mode,
  input wire logic                         o_watchdog_reset
);
  localparam standby_watchdog_pkg::mode_t M_RUN  = standby_watchdog_pkg::ST_RUN;
  localparam standby_watchdog_pkg::mode_t M_HALT = standby_watchdog_pkg::ST_HALT;
  localparam standby_watchdog_pkg::mode_t M_STOP = standby_watchdog_pkg::ST_STOP;
  localparam standby_watchdog_pkg::mode_t M_WAKE = standby_watchdog_pkg::ST_WAKE;

  // Quiet while the pin or the supply detector holds reset
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn || i_supply_drop_reset);

  property p_halt_gate; o_mode == M_HALT |-> !o_core_clk_en && o_timer_interrupt_clock_en && o_osc_enable; endproperty
  a_halt_gate: assert property (p_halt_gate) else $error("halt gating wrong");
  property p_stop_gate; o_mode == M_STOP |-> !o_osc_enable && !o_core_clk_en && !o_timer_interrupt_clock_en; endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("stop gating wrong");
  property p_halt_enter; o_core_clk_en && i_instr.valid && i_instr.opcode == 8'h7F && !i_irq_pending
    |=> o_mode == M_HALT; endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");
  property p_halt_exit; o_mode == M_HALT && i_irq_pending |=> o_mode == M_RUN; endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt not left on interrupt");
  property p_stop_hold; o_mode == M_STOP && !i_wake_input_pin |=> o_mode == M_STOP; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without wake");
  property p_wake; o_mode == M_STOP && i_wake_input_pin |-> ##[1:6] o_mode == M_WAKE; endproperty
  a_wake: assert property (p_wake) else $error("wake not seen");
  property p_wake_run; o_mode == M_WAKE ##1 o_mode == M_RUN |-> o_load_pc && o_pc_value == 16'h000C; endproperty
  a_wake_run: assert property (p_wake_run) else $error("no start load after wake");
  property p_flags; o_core_clk_en && i_instr.valid && i_instr.opcode == standby_watchdog_pkg::OP_WDOG_REFRESH
    |=> o_flags.upd && o_flags.z && !o_flags.s && !o_flags.v; endproperty
  a_flags: assert property (p_flags) else $error("refresh flags wrong");
  property p_wdog_rst; $rose(o_watchdog_reset) |-> ##[0:1] (!o_core_reset_n && o_mode == M_RUN); endproperty
  a_wdog_rst: assert property (p_wdog_rst) else $error("timeout did not reset core");
endmodule

bind standby_watchdog_control standby_watchdog_control_asserts #(.WDOG_LIMIT(WDOG_LIMIT), .OSC_START(OSC_START)) i_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_supply_drop_reset(i_supply_drop_reset),
  .i_wake_input_pin(i_wake_input_pin), .i_instr(i_instr), .i_irq_pending(i_irq_pending),
  .o_core_clk_en(o_core_clk_en), .o_timer_interrupt_clock_en(o_timer_interrupt_clock_en),
  .o_osc_enable(o_osc_enable), .o_core_reset_n(o_core_reset_n), .o_load_pc(o_load_pc),
  .o_pc_value(o_pc_value), .o_flags(o_flags), .o_mode(o_mode), .o_watchdog_reset(o_watchdog_reset)
);

// ### testbench/testbench.sv
// Self-checking bench for the standby and watchdog control block
`timescale 1ns/1ps
module testbench;
  localparam int WD = 100;
  localparam logic [7:0] REF = standby_watchdog_pkg::OP_WDOG_REFRESH;
  logic                         i_clk = 1'h0;
  logic                         i_resetn = 1'h0;
  logic                         drop = 1'h0;
  logic                         wake = 1'h0;
  logic                         irq = 1'h0;
  standby_watchdog_pkg::instr_t instr = '0;
  logic                         core_en, tmr_en, osc_en, rst_n, load_pc, wd_rst;
  logic [15:0]                  pc;
  standby_watchdog_pkg::flags_t flags;
  standby_watchdog_pkg::mode_t  mode;
  int                           num_errors = 0;
  int                           checks_done = 0;
  int                           n;

  always #4 i_clk = ~i_clk;

  standby_watchdog_control #(.WDOG_LIMIT(WD), .OSC_START(2)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_supply_drop_reset(drop), .i_wake_input_pin(wake),
    .i_instr(instr), .i_irq_pending(irq), .o_core_clk_en(core_en), .o_timer_interrupt_clock_en(tmr_en),
    .o_osc_enable(osc_en), .o_core_reset_n(rst_n), .o_load_pc(load_pc), .o_pc_value(pc),
    .o_flags(flags), .o_mode(mode), .o_watchdog_reset(wd_rst)
  );

  // Counts one comparison, reports a mismatch
  task automatic compare(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One instruction strobe, then settle past the taking edge
  task automatic send(input logic [7:0] op);
    @(posedge i_clk);
    instr <= '{1'h1, op};
    @(posedge i_clk);
    instr <= '0;
    @(negedge i_clk);
  endtask

  // Bounded wait for a level, cycles waited in n
  task automatic wait_hi(ref logic sig, input int lim);
    n = 0;
    while (sig !== 1'h1 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  task automatic t_reset();
    wait_hi(core_en, 10);
    compare("pc", 16'h000C, pc);
    compare("timer_en", 1'h1, tmr_en);
    send(REF);
    compare("flags", 4'hC, flags);
    @(negedge i_clk);
    compare("flags_upd", 1'h0, flags.upd);
  endtask

  task automatic t_halt();
    send(REF);
    send(8'hFF);
    send(8'h7F);
    compare("core_en", 1'h0, core_en);
    compare("timer_en", 1'h1, tmr_en);
    send(8'hFF);
    repeat (WD + 20) @(negedge i_clk);
    compare("mode", standby_watchdog_pkg::ST_HALT, mode);
    compare("wdog", 1'h0, wd_rst);
    @(posedge i_clk);
    irq <= 1'h1;
    @(posedge i_clk);
    irq <= 1'h0;
    @(negedge i_clk);
    compare("mode", standby_watchdog_pkg::ST_RUN, mode);
  endtask

  task automatic t_stop();
    send(REF);
    send(8'hFF);
    send(8'h6F);
    compare("osc", 1'h0, osc_en);
    compare("timer_en", 1'h0, tmr_en);
    @(posedge i_clk);
    irq <= 1'h1;
    repeat (WD + 20) @(negedge i_clk);
    compare("mode", standby_watchdog_pkg::ST_STOP, mode);
    compare("wdog", 1'h0, wd_rst);
    @(posedge i_clk);
    irq <= 1'h0;
    wake <= 1'h1;
    wait_hi(load_pc, 20);
    compare("load_pc", 1'h1, load_pc);
    compare("pc", 16'h000C, pc);
    @(posedge i_clk);
    wake <= 1'h0;
  endtask

  task automatic t_wdog();
    repeat (3) begin
      send(REF);
      repeat (WD - 20) @(negedge i_clk);
    end
    compare("wdog", 1'h0, wd_rst);
    send(REF);
    wait_hi(wd_rst, 2 * WD);
    compare("wdog_late", 1'h1, n <= WD + 3);
    compare("wdog_early", 1'h1, n >= WD - 4);
    compare("core_rst", 1'h0, rst_n);
    wait_hi(rst_n, 20);
    send(REF);
    send(8'h4F);
    send(8'hFF);
    send(8'h7F);
    wait_hi(wd_rst, 2 * WD);
    compare("wdog_halt", 1'h1, n <= WD);
    compare("mode", standby_watchdog_pkg::ST_RUN, mode);
    wait_hi(rst_n, 20);
  endtask

  task automatic t_supply();
    send(REF);
    send(8'hFF);
    send(8'h6F);
    @(posedge i_clk);
    drop <= 1'h1;
    @(negedge i_clk);
    compare("core_rst", 1'h0, rst_n);
    @(posedge i_clk);
    drop <= 1'h0;
    wait_hi(core_en, 10);
    compare("mode", standby_watchdog_pkg::ST_RUN, mode);
  endtask

  // Prints the counts and the verdict, ends the run
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    compare("core_rst", 1'h0, rst_n);
    i_resetn <= 1'h1;
    t_reset();
    t_halt();
    t_stop();
    t_wdog();
    t_supply();
    finish_test();
  end

  // Cuts a hung run short
  initial begin
    #50000;
    num_errors++;
    finish_test();
  end
endmodule
